//--- include/bbd_pkg.sv
// package: opcode map, decode table, types and constants for the bit/branch unit
package bbd_pkg;

	// ------------------------------------------------------------
	// opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] OP_NOP        = 8'h00;
	localparam logic [7:0] OP_FAR_JUMP   = 8'h02;
	localparam logic [7:0] OP_BR_SETCLR  = 8'h10;
	localparam logic [7:0] OP_FAR_CALL   = 8'h12;
	localparam logic [7:0] OP_BR_BSET    = 8'h20;
	localparam logic [7:0] OP_SUB_EXIT   = 8'h22;
	localparam logic [7:0] OP_BR_BCLR    = 8'h30;
	localparam logic [7:0] OP_INT_EXIT   = 8'h32;
	localparam logic [7:0] OP_BR_C       = 8'h40;
	localparam logic [7:0] OP_BR_NC      = 8'h50;
	localparam logic [7:0] OP_BR_AZ      = 8'h60;
	localparam logic [7:0] OP_BR_ANZ     = 8'h70;
	localparam logic [7:0] OP_OR_C_BIT   = 8'h72;
	localparam logic [7:0] OP_IDX_JUMP   = 8'h73;
	localparam logic [7:0] OP_SHORT      = 8'h80;
	localparam logic [7:0] OP_AND_C_BIT  = 8'h82;
	localparam logic [7:0] OP_BIT_FROM_C = 8'h92;
	localparam logic [7:0] OP_OR_C_NBIT  = 8'hA0;
	localparam logic [7:0] OP_C_FROM_BIT = 8'hA2;
	localparam logic [7:0] OP_AND_C_NBIT = 8'hB0;
	localparam logic [7:0] OP_CPL_BIT    = 8'hB2;
	localparam logic [7:0] OP_CPL_C      = 8'hB3;
	localparam logic [7:0] OP_CMP_A_IMM  = 8'hB4;
	localparam logic [7:0] OP_CMP_A_DIR  = 8'hB5;
	localparam logic [7:0] OP_CLR_BIT    = 8'hC2;
	localparam logic [7:0] OP_CLR_C      = 8'hC3;
	localparam logic [7:0] OP_SET_BIT    = 8'hD2;
	localparam logic [7:0] OP_SET_C      = 8'hD3;
	localparam logic [7:0] OP_DEC_DIR    = 8'hD5;

	// opcode groups matched on the low nibble (page jumps) or on upper bits
	localparam logic [3:0] PAGE_LOW_NIB  = 4'h1;
	localparam logic [6:0] CMP_IND_HI    = 7'h5B;
	localparam logic [4:0] CMP_REG_HI    = 5'h17;
	localparam logic [4:0] DEC_REG_HI    = 5'h1B;

	// ------------------------------------------------------------
	// address space, reset values and clocks per machine cycle
	// ------------------------------------------------------------
	localparam logic [7:0]  BIT_RAM_BASE = 8'h20;
	localparam logic [7:0]  SFR_BASE     = 8'h80;
	localparam logic [7:0]  SP_RESET     = 8'h07;
	localparam logic [15:0] PC_RESET     = 16'h0000;
	localparam int          CLKS_PER_MC  = 4;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic       known;
		logic [1:0] nbytes;
		logic [2:0] ncycles;
	} bbd_info_type;

	// one data-memory request; rdata returns the cycle after rd
	typedef struct packed {
		logic       rd;
		logic       we;
		logic       special_function_register;
		logic [7:0] addr;
		logic [7:0] wdata;
	} bbd_dreq_type;

	typedef enum logic [3:0] {
		S_OP   = 4'b0000,
		S_B1   = 4'b0001,
		S_B2   = 4'b0010,
		S_ADDR = 4'b0011,
		S_RD   = 4'b0100,
		S_PTR  = 4'b0101,
		S_EXEC = 4'b0110,
		S_PUSH = 4'b0111,
		S_WAIT = 4'b1000
	} bbd_state_type;

	// length and machine cycles of each opcode in the subset
	function automatic bbd_info_type bbd_decode(input logic [7:0] op);
		bbd_info_type d;
		d = '{known: 1'b1, nbytes: 2'h1, ncycles: 3'h1};
		if (op[3:0] == PAGE_LOW_NIB) begin
			d = '{1'b1, 2'h2, 3'h3};
		end else if (op[7:3] == CMP_REG_HI || op[7:1] == CMP_IND_HI) begin
			d = '{1'b1, 2'h3, 3'h4};
		end else if (op[7:3] == DEC_REG_HI) begin
			d = '{1'b1, 2'h2, 3'h3};
		end else begin
			case (op)
				OP_NOP, OP_CLR_C, OP_SET_C, OP_CPL_C:
					d = '{1'b1, 2'h1, 3'h1};
				OP_AND_C_BIT, OP_AND_C_NBIT, OP_OR_C_BIT, OP_OR_C_NBIT,
				OP_C_FROM_BIT, OP_BIT_FROM_C, OP_CLR_BIT, OP_SET_BIT,
				OP_CPL_BIT:
					d = '{1'b1, 2'h2, 3'h2};
				OP_FAR_JUMP, OP_FAR_CALL, OP_BR_BSET, OP_BR_BCLR,
				OP_BR_SETCLR, OP_CMP_A_IMM, OP_CMP_A_DIR, OP_DEC_DIR:
					d = '{1'b1, 2'h3, 3'h4};
				OP_SUB_EXIT, OP_INT_EXIT:
					d = '{1'b1, 2'h1, 3'h4};
				OP_SHORT, OP_BR_C, OP_BR_NC, OP_BR_AZ, OP_BR_ANZ:
					d = '{1'b1, 2'h2, 3'h3};
				OP_IDX_JUMP:
					d = '{1'b1, 2'h1, 3'h3};
				default:
					d = '{1'b0, 2'h1, 3'h1};
			endcase
		end
		return d;
	endfunction

endpackage

//--- logic/bbd_cycle_timer.sv
// machine-cycle divider that marks the last clock of an instruction
`timescale 1ns/10ps
module bbd_cycle_timer #(
	parameter int CLKS_PER_MC = bbd_pkg::CLKS_PER_MC
) (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	// control
	input  wire logic       start,
	input  wire logic [2:0] ncycles,
	// status
	output logic            last
);

	// ------------------------------------------------------------
	// phase divider and machine cycle countdown
	// ------------------------------------------------------------
	localparam int PW = $clog2(CLKS_PER_MC + 1);
	localparam logic [PW-1:0] PH_LAST = PW'(CLKS_PER_MC - 1);
	localparam logic [PW-1:0] PH_ONE  = PW'(1);

	logic [PW-1:0] ph_r;
	logic [2:0]    left_r;
	logic          active_r;
	logic          mc_en;

	assign mc_en = active_r && (ph_r == PH_LAST);
	assign last  = mc_en && (left_r == 3'h0);

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ph_r     <= '0;
			left_r   <= 3'h0;
			active_r <= 1'b0;
		end else if (start) begin
			// start clock is phase 0 of the first machine cycle
			ph_r     <= PH_ONE;
			left_r   <= ncycles - 3'h1;
			active_r <= 1'b1;
		end else if (mc_en) begin
			ph_r     <= '0;
			left_r   <= left_r - 3'h1;
			active_r <= (left_r != 3'h0);
		end else if (active_r) begin
			ph_r     <= ph_r + PH_ONE;
		end
	end

endmodule

//--- logic/bbd_decode_exec.sv
// bit-manipulation and branch instruction sequencer with its own pc and carry
`timescale 1ns/10ps
module bbd_decode_exec #(
	parameter int CLKS_PER_MC = bbd_pkg::CLKS_PER_MC
) (
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         nrst,
	// program memory, asynchronous read at code_addr
	output logic [15:0]       code_addr,
	input  wire logic [7:0]   code_rdata,
	// internal data memory and special registers
	output bbd_pkg::bbd_dreq_type dreq,
	input  wire logic [7:0]   data_rdata,
	// core state owned elsewhere
	input  wire logic [7:0]   acc,
	input  wire logic [15:0]  data_pointer,
	input  wire logic [1:0]   bank,
	// status
	output logic              carry,
	output logic [7:0]        sp,
	output logic              instr_done,
	output logic              prio_release,
	output logic              not_in_subset
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	bbd_pkg::bbd_state_type st_r;
	bbd_pkg::bbd_info_type  info;
	bbd_pkg::bbd_dreq_type  dreq_r;
	logic [7:0]  op_r, b1_r, b2_r;
	logic [15:0] pc_r;
	logic [7:0]  sp_r;
	logic        carry_r, ind_r, pop_r;
	logic        done_r, release_r, unsup_r;
	logic        last;

	assign info          = bbd_pkg::bbd_decode(code_rdata);
	assign code_addr     = pc_r;
	assign dreq          = dreq_r;
	assign carry         = carry_r;
	assign sp            = sp_r;
	assign instr_done    = done_r;
	assign prio_release  = release_r;
	assign not_in_subset = unsup_r;

	bbd_cycle_timer #(
		.CLKS_PER_MC (CLKS_PER_MC)
	) u_timer (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.start   (st_r == bbd_pkg::S_OP),
		.ncycles (info.ncycles),
		.last    (last)
	);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] bit_byte(input logic [7:0] b);
		if (b >= bbd_pkg::SFR_BASE)
			return {b[7:3], 3'h0};
		return bbd_pkg::BIT_RAM_BASE + {4'h0, b[6:3]};
	endfunction

	function automatic logic [7:0] put_bit(input logic [7:0] v,
		input logic [2:0] pos, input logic val);
		logic [7:0] r;
		r = v;
		r[pos] = val;
		return r;
	endfunction

	function automatic logic [1:0] info_len(input logic [7:0] op);
		bbd_pkg::bbd_info_type d;
		d = bbd_pkg::bbd_decode(op);
		return d.nbytes;
	endfunction

	// ------------------------------------------------------------
	// operand selection and execution
	// ------------------------------------------------------------
	logic        uses_bit, is_cmp_ind, is_cmp_reg, is_dec_reg, is_page;
	logic        is_exit, is_call;
	logic [7:0]  ea, rel, cmp_a, cmp_b, dec_v;
	logic        bit_in, take, wr_en, carry_nxt;
	logic [7:0]  wr_byte;
	logic [15:0] target, rel_target;

	assign is_page    = (op_r[3:0] == bbd_pkg::PAGE_LOW_NIB);
	assign is_cmp_ind = (op_r[7:1] == bbd_pkg::CMP_IND_HI);
	assign is_cmp_reg = (op_r[7:3] == bbd_pkg::CMP_REG_HI);
	assign is_dec_reg = (op_r[7:3] == bbd_pkg::DEC_REG_HI);
	assign is_exit    = (op_r == bbd_pkg::OP_SUB_EXIT) ||
		(op_r == bbd_pkg::OP_INT_EXIT);
	assign is_call    = (is_page && op_r[4]) ||
		(op_r == bbd_pkg::OP_FAR_CALL);
	assign bit_in     = data_rdata[b1_r[2:0]];
	assign dec_v      = data_rdata - 8'h01;
	// two-byte branches carry the displacement in byte 1
	assign rel        = (info_len(op_r) == 2'h2) ? b1_r : b2_r;
	assign rel_target = pc_r + {{8{rel[7]}}, rel};

	always_comb begin
		uses_bit = 1'b0;
		ea       = b1_r;
		case (op_r)
			bbd_pkg::OP_AND_C_BIT, bbd_pkg::OP_AND_C_NBIT,
			bbd_pkg::OP_OR_C_BIT, bbd_pkg::OP_OR_C_NBIT,
			bbd_pkg::OP_C_FROM_BIT, bbd_pkg::OP_BIT_FROM_C,
			bbd_pkg::OP_CLR_BIT, bbd_pkg::OP_SET_BIT,
			bbd_pkg::OP_CPL_BIT, bbd_pkg::OP_BR_BSET,
			bbd_pkg::OP_BR_BCLR, bbd_pkg::OP_BR_SETCLR: begin
				uses_bit = 1'b1;
				ea       = bit_byte(b1_r);
			end
			bbd_pkg::OP_CMP_A_DIR, bbd_pkg::OP_DEC_DIR:
				ea = b1_r;
			bbd_pkg::OP_SUB_EXIT, bbd_pkg::OP_INT_EXIT:
				ea = sp_r;
			default: begin
				if (is_cmp_ind)
					ea = {3'h0, bank, 2'h0, op_r[0]};
				else if (is_cmp_reg || is_dec_reg)
					ea = {3'h0, bank, op_r[2:0]};
			end
		endcase
	end

	always_comb begin
		take      = 1'b0;
		wr_en     = 1'b0;
		wr_byte   = data_rdata;
		carry_nxt = carry_r;
		target    = rel_target;
		cmp_a     = acc;
		cmp_b     = b1_r;
		case (op_r)
			bbd_pkg::OP_AND_C_BIT:  carry_nxt = carry_r & bit_in;
			bbd_pkg::OP_AND_C_NBIT: carry_nxt = carry_r & ~bit_in;
			bbd_pkg::OP_OR_C_BIT:   carry_nxt = carry_r | bit_in;
			bbd_pkg::OP_OR_C_NBIT:  carry_nxt = carry_r | ~bit_in;
			bbd_pkg::OP_C_FROM_BIT: carry_nxt = bit_in;
			bbd_pkg::OP_BIT_FROM_C: begin
				wr_en   = 1'b1;
				wr_byte = put_bit(data_rdata, b1_r[2:0], carry_r);
			end
			bbd_pkg::OP_CLR_C: carry_nxt = 1'b0;
			bbd_pkg::OP_SET_C: carry_nxt = 1'b1;
			bbd_pkg::OP_CPL_C: carry_nxt = ~carry_r;
			bbd_pkg::OP_CLR_BIT, bbd_pkg::OP_SET_BIT,
			bbd_pkg::OP_CPL_BIT: begin
				wr_en   = 1'b1;
				wr_byte = put_bit(data_rdata, b1_r[2:0],
					(op_r == bbd_pkg::OP_SET_BIT) ||
					((op_r == bbd_pkg::OP_CPL_BIT) && !bit_in));
			end
			bbd_pkg::OP_SHORT:  take = 1'b1;
			bbd_pkg::OP_IDX_JUMP: begin
				take   = 1'b1;
				target = data_pointer + {8'h00, acc};
			end
			bbd_pkg::OP_BR_AZ:   take = (acc == 8'h00);
			bbd_pkg::OP_BR_ANZ:  take = (acc != 8'h00);
			bbd_pkg::OP_BR_C:    take = carry_r;
			bbd_pkg::OP_BR_NC:   take = ~carry_r;
			bbd_pkg::OP_BR_BSET: take = bit_in;
			bbd_pkg::OP_BR_BCLR: take = ~bit_in;
			bbd_pkg::OP_BR_SETCLR: begin
				take    = bit_in;
				wr_en   = bit_in;
				wr_byte = put_bit(data_rdata, b1_r[2:0], 1'b0);
			end
			bbd_pkg::OP_FAR_JUMP, bbd_pkg::OP_FAR_CALL: begin
				take   = 1'b1;
				target = {b1_r, b2_r};
			end
			bbd_pkg::OP_CMP_A_DIR: begin
				cmp_b = data_rdata;
				take  = (cmp_a != cmp_b);
			end
			bbd_pkg::OP_CMP_A_IMM: take = (cmp_a != cmp_b);
			bbd_pkg::OP_DEC_DIR: begin
				wr_en   = 1'b1;
				wr_byte = dec_v;
				take    = (dec_v != 8'h00);
			end
			default: begin
				if (is_page) begin
					take   = 1'b1;
					target = {pc_r[15:11], op_r[7:5], b1_r};
				end else if (is_cmp_reg || is_cmp_ind) begin
					cmp_a = data_rdata;
					take  = (cmp_a != cmp_b);
				end else if (is_dec_reg) begin
					wr_en   = 1'b1;
					wr_byte = dec_v;
					take    = (dec_v != 8'h00);
				end
			end
		endcase
		// every compare, equal or not, leaves carry as the unsigned borrow
		if (op_r == bbd_pkg::OP_CMP_A_DIR || op_r == bbd_pkg::OP_CMP_A_IMM ||
			is_cmp_reg || is_cmp_ind)
			carry_nxt = (cmp_a < cmp_b);
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_r  <= bbd_pkg::S_OP;
			op_r  <= bbd_pkg::OP_NOP;
			b1_r  <= 8'h00;
			b2_r  <= 8'h00;
			ind_r <= 1'b0;
			pop_r <= 1'b0;
		end else begin
			case (st_r)
				bbd_pkg::S_OP: begin
					op_r  <= code_rdata;
					ind_r <= (code_rdata[7:1] == bbd_pkg::CMP_IND_HI);
					pop_r <= 1'b0;
					if (info.nbytes != 2'h1)
						st_r <= bbd_pkg::S_B1;
					else
						st_r <= bbd_pkg::S_ADDR;
				end
				bbd_pkg::S_B1: begin
					b1_r <= code_rdata;
					st_r <= (info_len(op_r) == 2'h3) ?
						bbd_pkg::S_B2 : bbd_pkg::S_ADDR;
				end
				bbd_pkg::S_B2: begin
					b2_r <= code_rdata;
					st_r <= bbd_pkg::S_ADDR;
				end
				bbd_pkg::S_ADDR: begin
					if (uses_bit || is_exit || is_cmp_ind || is_cmp_reg ||
						is_dec_reg || op_r == bbd_pkg::OP_CMP_A_DIR ||
						op_r == bbd_pkg::OP_DEC_DIR)
						st_r <= bbd_pkg::S_RD;
					else
						st_r <= bbd_pkg::S_EXEC;
				end
				bbd_pkg::S_RD: st_r <= ind_r ? bbd_pkg::S_PTR : bbd_pkg::S_EXEC;
				bbd_pkg::S_PTR: begin
					ind_r <= 1'b0;
					st_r  <= bbd_pkg::S_RD;
				end
				bbd_pkg::S_EXEC: begin
					if (is_exit && !pop_r) begin
						b2_r  <= data_rdata;
						pop_r <= 1'b1;
						st_r  <= bbd_pkg::S_RD;
					end else if (is_call) begin
						st_r <= bbd_pkg::S_PUSH;
					end else begin
						st_r <= bbd_pkg::S_WAIT;
					end
				end
				bbd_pkg::S_PUSH: st_r <= bbd_pkg::S_WAIT;
				bbd_pkg::S_WAIT: if (last) st_r <= bbd_pkg::S_OP;
				default: st_r <= bbd_pkg::S_OP;
			endcase
		end
	end

	// program counter and stack pointer
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pc_r <= bbd_pkg::PC_RESET;
			sp_r <= bbd_pkg::SP_RESET;
		end else if (st_r == bbd_pkg::S_OP || st_r == bbd_pkg::S_B1 ||
			st_r == bbd_pkg::S_B2) begin
			pc_r <= pc_r + 16'h0001;
		end else if (st_r == bbd_pkg::S_EXEC) begin
			if (is_exit && pop_r) begin
				pc_r <= {b2_r, data_rdata};
				sp_r <= sp_r - 8'h02;
			end else if (take && !is_call && !is_exit) begin
				pc_r <= target;
			end
		end else if (st_r == bbd_pkg::S_PUSH) begin
			// pc holds the return address until both bytes are pushed
			pc_r <= target;
			sp_r <= sp_r + 8'h02;
		end
	end

	// carry flag
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			carry_r <= 1'b0;
		else if (st_r == bbd_pkg::S_EXEC)
			carry_r <= carry_nxt;
	end

	// data memory port: reads in S_ADDR/S_PTR/pop, writes in S_EXEC/S_PUSH
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			dreq_r <= '0;
		end else begin
			dreq_r <= '0;
			case (st_r)
				bbd_pkg::S_ADDR: begin
					dreq_r.rd   <= 1'b1;
					dreq_r.addr <= ea;
					dreq_r.special_function_register  <= !is_cmp_ind && !is_exit &&
						!is_cmp_reg && !is_dec_reg && (ea >= bbd_pkg::SFR_BASE);
				end
				bbd_pkg::S_PTR: begin
					// indirect targets internal RAM only
					dreq_r.rd   <= 1'b1;
					dreq_r.addr <= data_rdata;
				end
				bbd_pkg::S_EXEC: begin
					if (is_exit && !pop_r) begin
						dreq_r.rd   <= 1'b1;
						dreq_r.addr <= sp_r - 8'h01;
					end else if (is_call) begin
						dreq_r.we    <= 1'b1;
						dreq_r.addr  <= sp_r + 8'h01;
						dreq_r.wdata <= pc_r[7:0];
					end else if (wr_en) begin
						dreq_r.we    <= 1'b1;
						dreq_r.addr  <= ea;
						// a direct decrement writes back where it read from
						dreq_r.special_function_register   <= (uses_bit ||
							op_r == bbd_pkg::OP_DEC_DIR) &&
							(ea >= bbd_pkg::SFR_BASE);
						dreq_r.wdata <= wr_byte;
					end
				end
				bbd_pkg::S_PUSH: begin
					dreq_r.we    <= 1'b1;
					dreq_r.addr  <= sp_r + 8'h02;
					dreq_r.wdata <= pc_r[15:8];
				end
				default: dreq_r <= '0;
			endcase
		end
	end

	// status pulses
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			done_r    <= 1'b0;
			release_r <= 1'b0;
			unsup_r   <= 1'b0;
		end else begin
			done_r    <= (st_r == bbd_pkg::S_WAIT) && last;
			release_r <= (st_r == bbd_pkg::S_EXEC) && pop_r &&
				(op_r == bbd_pkg::OP_INT_EXIT);
			unsup_r   <= (st_r == bbd_pkg::S_OP) && !info.known;
		end
	end

endmodule

//--- tb/bbd_decode_exec_sva.sv
// port assertions for the bit/branch sequencer
`timescale 1ns/10ps
module bbd_decode_exec_sva #(
	parameter int CLKS_PER_MC = 4
) (
	// clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  nrst,
	// watched outputs
	input  wire logic [15:0]           code_addr,
	input  wire bbd_pkg::bbd_dreq_type dreq,
	input  wire logic [7:0]            sp,
	input  wire logic                  instr_done,
	input  wire logic                  prio_release,
	input  wire logic                  not_in_subset
);
	localparam int MC  = CLKS_PER_MC;
	localparam int MC4 = 4 * CLKS_PER_MC;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	start_fetch_a: assert property ($rose(nrst) |->
		(code_addr == 16'h0000 && sp == 8'h07) ##[MC:MC4] instr_done)
		else $error("first instruction does not start at zero or finish");
	done_pulse_a: assert property (instr_done |=> !instr_done)
		else $error("completion pulse longer than one cycle");
	done_gap_a: assert property (instr_done |=> !instr_done [*3])
		else $error("instruction shorter than one machine cycle");
	done_bound_a: assert property (instr_done |-> ##[MC:MC4] instr_done)
		else $error("instruction longer than four machine cycles");
	rw_excl_a: assert property (!(dreq.rd && dreq.we))
		else $error("read and write in one cycle");
	idle_zero_a: assert property (!(dreq.rd || dreq.we) |-> dreq == '0)
		else $error("idle data request not cleared");
	sfr_flag_a: assert property (dreq.special_function_register |-> dreq.addr[7])
		else $error("special register flag below address 128");
	sp_step_a: assert property (!$stable(sp) |->
		(sp == $past(sp) + 8'h02 || sp == $past(sp) - 8'h02))
		else $error("stack pointer moved by other than two");
	prio_inside_a: assert property (prio_release |-> ##[0:MC4] instr_done)
		else $error("priority release outside an instruction");
	skip_short_a: assert property (not_in_subset |-> ##[0:MC] instr_done)
		else $error("unknown opcode not skipped in one cycle");

	cover property (prio_release);
	cover property (not_in_subset);
	cover property (dreq.we);
	cover property (!$stable(sp));
endmodule

bind bbd_decode_exec bbd_decode_exec_sva #(.CLKS_PER_MC(CLKS_PER_MC))
	bbd_decode_exec_sva_inst (.ref_clk(ref_clk), .nrst(nrst),
	.code_addr(code_addr), .dreq(dreq), .sp(sp), .instr_done(instr_done),
	.prio_release(prio_release), .not_in_subset(not_in_subset));

//--- tb/bbd_decode_exec_tb.sv
// self-checking bench for the bit/branch sequencer
`timescale 1ns/10ps
module bbd_decode_exec_tb;
	logic                  ref_clk, nrst, carry, instr_done;
	logic                  prio_release, not_in_subset;
	logic [15:0]           code_addr, data_pointer, epc;
	logic [7:0]            code_rdata, data_rdata, acc, sp, esp;
	logic [1:0]            bank;
	bbd_pkg::bbd_dreq_type dreq;
	logic [31:0]           seed = 32'h1DC0;
	logic [7:0]            mram [512];
	logic                  ec, enis, eprio, snis, sprio;
	int                    ecyc, cnt, ninstr, ncyc, miscompares, n_tests;
	// only subset encodings plus 8'hE4, which is outside the subset, are issued, no self-move of the accumulator
	logic [7:0] optab [34] = '{8'h00, 8'hC3, 8'hD3, 8'hB3, 8'hC2,
		8'hD2, 8'hB2, 8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2, 8'h92, 8'h80,
		8'h40, 8'h50, 8'h60, 8'h70, 8'h20, 8'h30, 8'h10, 8'hB4, 8'hB5,
		8'hB8, 8'hB6, 8'hD8, 8'hD5, 8'h73, 8'h01, 8'h02, 8'h12, 8'h22,
		8'h32, 8'hE4};

	bbd_decode_exec #(.CLKS_PER_MC(4)) bbd_decode_exec_inst (
		.ref_clk(ref_clk), .nrst(nrst), .code_addr(code_addr),
		.code_rdata(code_rdata), .dreq(dreq), .data_rdata(data_rdata),
		.acc(acc), .data_pointer(data_pointer), .bank(bank), .carry(carry), .sp(sp),
		.instr_done(instr_done), .prio_release(prio_release),
		.not_in_subset(not_in_subset));
	bbd_mem_model bbd_mem_model_inst (.ref_clk(ref_clk),
		.code_addr(code_addr), .code_rdata(code_rdata), .dreq(dreq),
		.data_rdata(data_rdata));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [8:0] bitix(input logic [7:0] b);
		return b[7] ? {1'b1, b & 8'hF8} : {1'b0, 8'h20 + {4'h0, b[6:3]}};
	endfunction

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected %s expected %0h seen %0h", nm, e, s);
		end
	endtask

	task automatic results();
		if (miscompares == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------
	// reference model: place one random instruction, predict it
	// ------------------------------------------------------------
	task automatic step();
		logic [7:0]  op, b1, b2, v, w, ptr;
		logic [8:0]  bx, dx, rg;
		logic [15:0] n1, n2, n3, r2, r3, ret;
		logic        bv, cmp, psh;
		seed = lfsr(seed);
		op = optab[seed[7:0] % 34];
		b1 = seed[15:8];
		b2 = seed[23:16];
		if (op == 8'hB8 || op == 8'hD8) op[2:0] = seed[26:24];
		if (op == 8'hB6) op[0] = seed[27];
		if (op == 8'h01) op[7:4] = seed[31:28];
		seed = lfsr(seed);
		acc = seed[26] ? seed[7:0] : 8'h00;
		data_pointer = seed[23:8];
		bank = seed[25:24];
		if (seed[27]) b1 = acc;
		bbd_mem_model_inst.rom[epc] = op;
		bbd_mem_model_inst.rom[epc + 16'h0001] = b1;
		bbd_mem_model_inst.rom[epc + 16'h0002] = b2;
		n1 = epc + 16'h0001;
		n2 = epc + 16'h0002;
		n3 = epc + 16'h0003;
		r2 = n2 + {{8{b1[7]}}, b1};
		r3 = n3 + {{8{b2[7]}}, b2};
		bx = bitix(b1);
		bv = mram[bx][b1[2:0]];
		dx = {b1[7], b1};
		rg = {4'h0, bank, op[2:0]};
		ptr = mram[{4'h0, bank, 2'b00, op[0]}];
		{cmp, psh, enis, eprio} = 4'h0;
		ecyc = 2;
		epc = n2;
		casez (op)
		8'h00, 8'hE4: begin ecyc = 1; epc = n1; enis = op[7]; end
		8'hC3: begin ecyc = 1; epc = n1; ec = 1'b0; end
		8'hD3: begin ecyc = 1; epc = n1; ec = 1'b1; end
		8'hB3: begin ecyc = 1; epc = n1; ec = ~ec; end
		8'hC2: mram[bx][b1[2:0]] = 1'b0;
		8'hD2: mram[bx][b1[2:0]] = 1'b1;
		8'hB2: mram[bx][b1[2:0]] = ~bv;
		8'h82: ec = ec & bv;
		8'hB0: ec = ec & ~bv;
		8'h72: ec = ec | bv;
		8'hA0: ec = ec | ~bv;
		8'hA2: ec = bv;
		8'h92: mram[bx][b1[2:0]] = ec;
		8'h80: begin ecyc = 3; epc = r2; end
		8'h40: begin ecyc = 3; epc = ec ? r2 : n2; end
		8'h50: begin ecyc = 3; epc = ec ? n2 : r2; end
		8'h60: begin ecyc = 3; epc = (acc == 8'h00) ? r2 : n2; end
		8'h70: begin ecyc = 3; epc = (acc != 8'h00) ? r2 : n2; end
		8'h20: begin ecyc = 4; epc = bv ? r3 : n3; end
		8'h30: begin ecyc = 4; epc = bv ? n3 : r3; end
		8'h10: begin ecyc = 4; epc = bv ? r3 : n3; mram[bx][b1[2:0]] = 1'b0; end
		8'hB4: begin cmp = 1'b1; v = acc; w = b1; end
		8'hB5: begin cmp = 1'b1; v = acc; w = mram[dx]; end
		8'b1011_011?: begin cmp = 1'b1; v = mram[{1'b0, ptr}]; w = b1; end
		8'b1011_1???: begin cmp = 1'b1; v = mram[rg]; w = b1; end
		8'b1101_1???: begin
			ecyc = 3;
			mram[rg] = mram[rg] - 8'h01;
			epc = (mram[rg] != 8'h00) ? r2 : n2;
		end
		8'hD5: begin
			ecyc = 4;
			mram[dx] = mram[dx] - 8'h01;
			epc = (mram[dx] != 8'h00) ? r3 : n3;
		end
		8'h73: begin ecyc = 3; epc = data_pointer + {8'h00, acc}; end
		8'h02, 8'h12: begin ecyc = 4; epc = {b1, b2}; psh = op[4]; end
		8'h22, 8'h32: begin
			ecyc = 4;
			epc = {mram[{1'b0, esp}], mram[{1'b0, esp - 8'h01}]};
			esp = esp - 8'h02;
			eprio = op[4];
		end
		8'h?1: begin ecyc = 3; epc = {n2[15:11], op[7:5], b1}; psh = op[4]; end
		default: ;
		endcase
		if (psh) begin
			ret = (op == 8'h12) ? n3 : n2;
			mram[{1'b0, esp + 8'h01}] = ret[7:0];
			mram[{1'b0, esp + 8'h02}] = ret[15:8];
			esp = esp + 8'h02;
		end
		if (cmp) begin
			ecyc = 4;
			epc = (v != w) ? r3 : n3;
			ec = v < w;
		end
	endtask

	task automatic do_reset();
		nrst = 1'b0;
		repeat (12) @(negedge ref_clk);
		chk("reset pc", 32'h0, code_addr);
		chk("reset sp", 32'h7, sp);
		chk("reset carry", 32'h0, carry);
		chk("reset dreq", 32'h0, dreq);
		epc = 16'h0000;
		ec = 1'b0;
		esp = 8'h07;
		{snis, sprio} = 2'b00;
		step();
		nrst = 1'b1;
		// the release edge fetches the opcode, as after a completion pulse
		cnt = 0;
	endtask

	// ------------------------------------------------------------
	// main sequence and hang guard
	// ------------------------------------------------------------
	initial begin
		{nrst, acc, data_pointer, bank} = '0;
		for (int i = 0; i < 512; i++) begin
			seed = lfsr(seed);
			bbd_mem_model_inst.ram[i] = seed[7:0];
			mram[i] = seed[7:0];
		end
		do_reset();
		while (ninstr < 400) begin
			@(negedge ref_clk);
			cnt++;
			if (not_in_subset === 1'b1) snis = 1'b1;
			if (prio_release === 1'b1) sprio = 1'b1;
			if (instr_done === 1'b1) begin
				chk("pc", epc, code_addr);
				chk("carry", ec, carry);
				chk("sp", esp, sp);
				chk("cycles", ecyc * 4, cnt);
				chk("skip", enis, snis);
				chk("release", eprio, sprio);
				{snis, sprio} = 2'b00;
				cnt = 0;
				ninstr++;
				if (ninstr == 200)
					do_reset();
				else
					step();
			end
		end
		for (int i = 0; i < 512; i++)
			chk("ram", mram[i], bbd_mem_model_inst.ram[i]);
		results();
	end

	always @(posedge ref_clk) begin
		ncyc++;
		if (ncyc == 20000) begin
			miscompares++;
			results();
		end
	end
endmodule

//--- tb/bbd_mem_model.sv
// program and data memory model facing the bit/branch sequencer
`timescale 1ns/10ps
module bbd_mem_model (
	// clock
	input  wire logic                  ref_clk,
	// program side
	input  wire logic [15:0]           code_addr,
	output logic [7:0]                 code_rdata,
	// data side
	input  wire bbd_pkg::bbd_dreq_type dreq,
	output logic [7:0]                 data_rdata
);
	logic [7:0] rom [65536];
	logic [7:0] ram [512];
	logic [7:0] last_r = 8'h00;
	logic       valid_r = 1'b0;

	// ------------------------------------------------------------
	// memories
	// ------------------------------------------------------------
	assign code_rdata = rom[code_addr];
	// outside the answer cycle the bus shows a changed byte, never a stale one
	assign data_rdata = valid_r ? last_r : ~last_r;

	always @(posedge ref_clk) begin
		valid_r <= dreq.rd;
		if (dreq.rd)
			last_r <= ram[{dreq.special_function_register, dreq.addr}];
		if (dreq.we)
			ram[{dreq.special_function_register, dreq.addr}] <= dreq.wdata;
	end
endmodule
